/* rtl/awr_defs.vh */
// Offsets, reset values and field codes of the ADC result and window slice
`ifndef AWR_DEFS_VH
`define AWR_DEFS_VH

// Special-function-register addresses
`define AWR_ADDR_RESULT_LOW      8'hBD
`define AWR_ADDR_UPPER_THR_LOW   8'hC3
`define AWR_ADDR_UPPER_THR_HIGH  8'hC4
`define AWR_ADDR_LOWER_THR_LOW   8'hC5
`define AWR_ADDR_LOWER_THR_HIGH  8'hC6

// Reset values of the threshold bytes
`define AWR_RST_UPPER_THR_LOW    8'hFF
`define AWR_RST_UPPER_THR_HIGH   8'hFF
`define AWR_RST_LOWER_THR_LOW    8'h00
`define AWR_RST_LOWER_THR_HIGH   8'h00

// Value returned for an unmapped address
`define AWR_RDATA_IDLE           8'h00

// Result justify setting codes
`define AWR_JST_RIGHT            3'h0
`define AWR_JST_SHR1             3'h1
`define AWR_JST_SHR2             3'h2
`define AWR_JST_SHR3             3'h3
`define AWR_JST_LEFT12           3'h4

// Left shift that left-justifies a 12-bit result in 16 bits
`define AWR_LEFT12_SHIFT         4

`endif

/* rtl/awr_cmp16.v */
// Unsigned 16-bit magnitude comparator used by the window check
`timescale 1ns/10ps
`default_nettype none

module awr_cmp16 (
    // Operands
    input  wire [15:0] i_value,
    input  wire [15:0] i_limit,
    // Results
    output wire        o_above,
    output wire        o_below
);

    // Value strictly above limit
    assign o_above = (i_value > i_limit);
    // Value strictly below limit
    assign o_below = (i_value < i_limit);

endmodule // awr_cmp16

`default_nettype wire

/* rtl/awr_regs.v */
// ADC result low byte and window-compare threshold registers
//
// Functional notes
// R1: Result low read returns formatted accumulator low byte
// R2: Result low write loads accumulator low byte
// R3: Shifted results read zeros in upper bits
// R4: Software avoids result writes in sync mode
// R5: Upper threshold high holds compare bits 15:8
// R6: Upper threshold low holds compare bits 7:0
// R7: Lower threshold high holds compare bits 15:8
// R8: Lower threshold low holds compare bits 7:0
// R9: In 8-bit mode software zeroes low thresholds
// R10: Completed conversion inside window sets compare flag
`timescale 1ns/10ps
`default_nettype none
`include "awr_defs.vh"

// Byte view of the conversion accumulator and the two window limits.
// Everything here sits in the core clock domain, so the strobes and the
// accumulator are used as they arrive, with no resynchronising stages.
// The high accumulator byte and the engine itself live elsewhere; this
// slice only formats, stores and compares.
module awr_regs (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_sys_rst,
    // Special-function-register access from the core
    input  wire [7:0]  i_sfr_addr,
    input  wire        i_sfr_wr,
    input  wire        i_sfr_rd,
    input  wire [7:0]  i_sfr_wdata,
    output reg  [7:0]  o_sfr_rdata,
    output reg         o_sfr_rvalid,
    // Accumulator held by the conversion engine
    input  wire [15:0] i_acc,
    output wire        o_acc_low_wr,
    output reg  [7:0]  o_acc_low_data,
    // Converter settings
    input  wire [2:0]  i_result_justify_setting,
    input  wire        i_sync_mode,
    // Window compare
    input  wire        i_conv_done,
    input  wire        i_win_flag_clr,
    output reg         o_win_flag,
    output wire [15:0] o_upper_threshold,
    output wire [15:0] o_lower_threshold
);

    // Threshold storage bytes
    // Reset leaves an empty window, so no flag until limits are set
    reg  [7:0]  upper_threshold_low;   // Greater-than bits 7:0
    reg  [7:0]  upper_threshold_high;  // Greater-than bits 15:8
    reg  [7:0]  lower_threshold_low;   // Less-than bits 7:0
    reg  [7:0]  lower_threshold_high;  // Less-than bits 15:8

    // Formatting and decode
    reg  [15:0] next_result;           // Formatted accumulator
    reg  [7:0]  next_rdata;            // Read mux output
    reg         wr_result_low;         // Write hits result low byte
    wire        acc_above;             // Result above greater-than value
    wire        acc_below;             // Result below less-than value
    wire        in_window;             // Result inside window

    // Full thresholds toward comparator and other converter parts
    // Driven straight from the bytes, so they change at the write edge
    assign o_upper_threshold = {upper_threshold_high,
                                upper_threshold_low};  // R5 R6
    assign o_lower_threshold = {lower_threshold_high,
                                lower_threshold_low};  // R7 R8

    // Apply justification; right shifts fill upper bits with zeros
    // Logical shifts only: an arithmetic shift would smear the top bit.
    // The left shift drops the bits pushed past bit 15 on purpose.
    // Unused codes fall back to the plain value rather than to zero.
    always @* begin
        case (i_result_justify_setting)
            `AWR_JST_RIGHT: begin
                next_result = i_acc;
            end
            `AWR_JST_SHR1: begin
                next_result = i_acc >> 1;  // R3
            end
            `AWR_JST_SHR2: begin
                next_result = i_acc >> 2;  // R3
            end
            `AWR_JST_SHR3: begin
                next_result = i_acc >> 3;  // R3
            end
            `AWR_JST_LEFT12: begin
                next_result = i_acc << `AWR_LEFT12_SHIFT;
            end
            default: begin
                next_result = i_acc;
            end
        endcase
    end

    // Read data selection; unmapped addresses read zero
    // Pure selection: a read never disturbs the accumulator or the flag.
    // The result byte follows the live accumulator, not a snapshot.
    always @* begin
        case (i_sfr_addr)
            `AWR_ADDR_RESULT_LOW: begin
                next_rdata = next_result[7:0];  // R1
            end
            `AWR_ADDR_UPPER_THR_LOW: begin
                next_rdata = upper_threshold_low;
            end
            `AWR_ADDR_UPPER_THR_HIGH: begin
                next_rdata = upper_threshold_high;
            end
            `AWR_ADDR_LOWER_THR_LOW: begin
                next_rdata = lower_threshold_low;
            end
            `AWR_ADDR_LOWER_THR_HIGH: begin
                next_rdata = lower_threshold_high;
            end
            default: begin
                next_rdata = `AWR_RDATA_IDLE;
            end
        endcase
    end

    // Result low write decode; sync mode is left to software
    // Not gated by sync mode: dropping the write silently would hide a
    // software fault, so the store simply goes through as written.
    always @* begin
        wr_result_low = i_sfr_wr &&
                        (i_sfr_addr == `AWR_ADDR_RESULT_LOW);  // R2
    end

    // Accumulator low-byte load strobe toward the conversion engine
    assign o_acc_low_wr = wr_result_low;  // R2

    // Data of the load strobe; held between writes
    // The byte lands one edge after the strobe; the engine must use it
    // from the following cycle, or take the write data directly.
    // Any write refreshes it, so it is only meaningful after a strobe.
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_acc_low_data <= 8'h00;
        end else if (i_sfr_wr) begin
            o_acc_low_data <= i_sfr_wdata;  // R2
        end
    end

    // Threshold register writes
    // Each byte is independent, with no shadow latch for the pair, so a
    // compare between the two byte writes sees a half-updated limit.
    // Software should change limits only while conversions are idle.
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            upper_threshold_low  <= `AWR_RST_UPPER_THR_LOW;
            upper_threshold_high <= `AWR_RST_UPPER_THR_HIGH;
            lower_threshold_low  <= `AWR_RST_LOWER_THR_LOW;
            lower_threshold_high <= `AWR_RST_LOWER_THR_HIGH;
        end else if (i_sfr_wr) begin
            case (i_sfr_addr)
                `AWR_ADDR_UPPER_THR_LOW: begin
                    upper_threshold_low <= i_sfr_wdata;  // R6
                end
                `AWR_ADDR_UPPER_THR_HIGH: begin
                    upper_threshold_high <= i_sfr_wdata;  // R5
                end
                `AWR_ADDR_LOWER_THR_LOW: begin
                    lower_threshold_low <= i_sfr_wdata;  // R8
                end
                `AWR_ADDR_LOWER_THR_HIGH: begin
                    lower_threshold_high <= i_sfr_wdata;  // R7
                end
                default: begin
                    upper_threshold_low <= upper_threshold_low;
                end
            endcase
        end
    end

    // Registered read answer, one cycle after the read strobe
    // One cycle of latency buys a clean flop output toward the core bus.
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sfr_rdata  <= `AWR_RDATA_IDLE;
            o_sfr_rvalid <= 1'b0;
        end else begin
            o_sfr_rvalid <= i_sfr_rd;
            if (i_sfr_rd) begin
                o_sfr_rdata <= next_rdata;  // R1
            end
        end
    end

    // Comparator against the greater-than value
    // Both compares use the formatted value, as software reads it.
    awr_cmp16 u_cmp_upper (
        .i_value (next_result),
        .i_limit (o_upper_threshold),
        .o_above (acc_above),
        .o_below ()
    );

    // Comparator against the less-than value
    awr_cmp16 u_cmp_lower (
        .i_value (next_result),
        .i_limit (o_lower_threshold),
        .o_above (),
        .o_below (acc_below)
    );

    // Inside the window: above greater-than and below less-than
    // A result equal to either limit does not count as inside
    assign in_window = acc_above && acc_below;

    // Sticky window flag; a new hit wins over a clear
    // Losing a hit to a clear in the same cycle would drop an event.
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_win_flag <= 1'b0;
        end else if (i_conv_done && in_window) begin
            o_win_flag <= 1'b1;  // R10
        end else if (i_win_flag_clr) begin
            o_win_flag <= 1'b0;
        end
    end

endmodule // awr_regs

`default_nettype wire

/* testbench/awr_regs_chk.sv */
// Checker of the ADC result and window register slice
`timescale 1ns/10ps
`default_nettype none
module awr_regs_chk (
    // Clock, reset and strobes
    input wire        i_ref_clk, i_sys_rst, i_sfr_wr, i_sfr_rd,
    // Byte wide signals
    input wire [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_acc_low_data,
    // Accumulator and thresholds
    input wire [15:0] i_acc, o_upper_threshold, o_lower_threshold,
    // Settings and flags
    input wire [2:0]  i_result_justify_setting,
    input wire        o_sfr_rvalid, o_acc_low_wr, i_conv_done, i_win_flag_clr,
    input wire        o_win_flag, i_sync_mode
);
    // Accumulator after justification
    function automatic [15:0] fmt(input [15:0] a, input [2:0] j);
        case (j)
            3'h1: fmt = a >> 1;
            3'h2: fmt = a >> 2;
            3'h3: fmt = a >> 3;
            3'h4: fmt = a << 4;
            default: fmt = a;
        endcase
    endfunction
    wire [15:0] acc_fmt = fmt(i_acc, i_result_justify_setting); // Expected
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // Write strobe aimed at one address
    sequence s_wr(a);
        i_sfr_wr && i_sfr_addr == a;
    endsequence
    chk_rd_answer: assert property (i_sfr_rd |=> o_sfr_rvalid)
        else $error("read answer missing");
    chk_rvalid_pulse: assert property (!i_sfr_rd |=> !o_sfr_rvalid)
        else $error("read answer not a single pulse");
    chk_result_read: assert property (i_sfr_rd && i_sfr_addr == 8'hBD
        |=> o_sfr_rdata == $past(acc_fmt[7:0]))
        else $error("result byte wrong");
    chk_acc_strobe: assert property (o_acc_low_wr ==
        (i_sfr_wr && i_sfr_addr == 8'hBD)) else $error("load strobe wrong");
    chk_acc_data: assert property (s_wr(8'hBD) |=>
        o_acc_low_data == $past(i_sfr_wdata)) else $error("load data wrong");
    chk_upper_high: assert property (s_wr(8'hC4) |=>
        o_upper_threshold[15:8] == $past(i_sfr_wdata))
        else $error("upper high wrong");
    chk_upper_low: assert property (s_wr(8'hC3) |=>
        o_upper_threshold[7:0] == $past(i_sfr_wdata))
        else $error("upper low wrong");
    chk_lower_high: assert property (s_wr(8'hC6) |=>
        o_lower_threshold[15:8] == $past(i_sfr_wdata))
        else $error("lower high wrong");
    chk_lower_low: assert property (s_wr(8'hC5) |=>
        o_lower_threshold[7:0] == $past(i_sfr_wdata))
        else $error("lower low wrong");
    chk_win_set: assert property (i_conv_done &&
        acc_fmt > o_upper_threshold && acc_fmt < o_lower_threshold
        |=> o_win_flag) else $error("no flag");
    chk_win_clear: assert property (i_win_flag_clr && !i_conv_done
        |=> !o_win_flag) else $error("flag not cleared");
    chk_win_hold: assert property (o_win_flag && !i_win_flag_clr
        |=> o_win_flag) else $error("flag lost without clear");
endmodule // awr_regs_chk
bind awr_regs awr_regs_chk u_chk (.*);
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of the ADC result and window register slice
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    // Design inputs, quiet at time zero
    logic        i_ref_clk = 0, i_sys_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0;
    logic        i_sync_mode = 0, i_conv_done = 0, i_win_flag_clr = 0;
    logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
    logic [15:0] i_acc = 16'h0000;
    logic [2:0]  i_result_justify_setting = 3'h0;
    // Design outputs
    wire [7:0]   o_sfr_rdata, o_acc_low_data;
    wire         o_sfr_rvalid, o_acc_low_wr, o_win_flag;
    wire [15:0]  o_upper_threshold, o_lower_threshold;
    int          errors = 0, checks_done = 0;
    logic [7:0]  rd; // Last read byte
    logic        strobe; // Load strobe seen during the last write
    // Rows: write flag, address, data, justify, accumulator, expected
    logic [47:0] rows [16] = '{48'h0C30000000FF, 48'h0C40000000FF,
        48'h0C5000000000, 48'h0C6000000000, 48'h0BD000000000,
        48'h1C4120000012, 48'h1C3340000034, 48'h1C6560000056,
        48'h1C5780000078, 48'h1C7550000000, 48'h0BD0009ABCBC,
        48'h0BD0019ABC5E, 48'h0BD0029ABCAF, 48'h0BD0039ABC57,
        48'h0BD0049ABCC0, 48'h0BD0079ABCBC};
    always #25 i_ref_clk = ~i_ref_clk;
    awr_regs uut (.*);
    // One-cycle write strobe
    task automatic wr_reg(input [7:0] a, input [7:0] d);
        @(negedge i_ref_clk);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1;
        @(posedge i_ref_clk);
        strobe = o_acc_low_wr;
        @(negedge i_ref_clk);
        i_sfr_wr = 0;
    endtask
    // One-cycle read strobe, answer taken a cycle later
    task automatic rd_reg(input [7:0] a);
        @(negedge i_ref_clk);
        i_sfr_addr = a;
        i_sfr_rd = 1;
        @(negedge i_ref_clk);
        i_sfr_rd = 0;
        rd = o_sfr_rdata;
        `CHK(o_sfr_rvalid, 1'b1)
    endtask
    // Conversion and clear pulses, then flag check
    task automatic conv(input [15:0] a, input [2:0] j, input c, l, e);
        @(negedge i_ref_clk);
        i_acc = a;
        i_result_justify_setting = j;
        i_conv_done = c;
        i_win_flag_clr = l;
        @(negedge i_ref_clk);
        i_conv_done = 0;
        i_win_flag_clr = 0;
        `CHK(o_win_flag, e)
    endtask
    // Counts and verdict
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge i_ref_clk);
        @(negedge i_ref_clk) i_sys_rst = 0;
        foreach (rows[k]) begin
            i_acc = rows[k][23:8];
            i_result_justify_setting = rows[k][26:24];
            if (rows[k][44]) wr_reg(rows[k][43:36], rows[k][35:28]);
            rd_reg(rows[k][43:36]);
            `CHK(rd, rows[k][7:0])
        end
        `CHK(o_upper_threshold, 16'h1234)
        `CHK(o_lower_threshold, 16'h5678)
        $display("test register rows done");
        wr_reg(8'hBD, 8'h5A);
        `CHK(strobe, 1'b1)
        `CHK(o_acc_low_data, 8'h5A)
        $display("test result write done");
        conv(16'h3000, 3'h0, 1, 0, 1);
        conv(16'h3000, 3'h0, 0, 1, 0);
        conv(16'h0300, 3'h4, 1, 1, 1);
        conv(16'h0000, 3'h0, 0, 1, 0);
        conv(16'h5678, 3'h0, 1, 0, 0);
        conv(16'h1234, 3'h0, 1, 0, 0);
        conv(16'hA000, 3'h2, 1, 0, 1);
        $display("test window done");
        wr_reg(8'hC3, 8'h00);
        `CHK(strobe, 1'b0)
        wr_reg(8'hC5, 8'h00);
        conv(16'h1200, 3'h0, 1, 1, 0);
        conv(16'h1201, 3'h0, 1, 0, 1);
        conv(16'h5600, 3'h0, 1, 1, 0);
        $display("test zero low bytes done");
        @(negedge i_ref_clk) i_sys_rst = 1;
        @(negedge i_ref_clk) i_sys_rst = 0;
        `CHK(o_upper_threshold, 16'hFFFF)
        `CHK(o_lower_threshold, 16'h0000)
        `CHK(o_win_flag, 1'b0)
        $display("test second reset done");
        report_and_stop;
    end
    // Watchdog, far beyond the fewer than 100 cycles needed
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
